// ==== core/dram_module_host.sv ====
// host controller driving an asynchronous dram module
// Behaviour
// - row half then column half of the address go out on shared lines.
// - write enable high for reads, low for writes.
// - page access holds row low and toggles column with new addresses.
// - raising row ends a page; another row needs a new row cycle.
// - output enable disables idle banks sharing data lines.
// - both strobes high end the cycle; row high time is precharge.
// - every row refreshed within each refresh period, any order.
// - refresh 2048 rows per 32 ms, or spread over 128 ms.
// - self refresh entered by column-before-row with row held low.
// - distributed column-before-row refresh one row per interval.
// - self refresh ends by holding row high for exit precharge.
// - after self refresh, distributed refresh means no burst needed.
// - row held low at least 100 us to enter self refresh.
// - after power-up wait 100 us and give eight refresh cycles.
// - presence-detect gate low lets the presence bits be read.
// - row held high at least exit precharge before next cycle.
`timescale 1ns/100ps
module dram_module_host #(
   parameter int POWERUP_CYCLES = dram_host_pkg::POWERUP_CYC,
   parameter int SELF_PULSE_CYCLES = dram_host_pkg::SELF_PULSE_CYC,
   parameter int REFRESH_INTERVAL = dram_host_pkg::DIST_REFRESH_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // user command port
   input wire logic cmdValid,
   input wire dram_host_pkg::cmd_t cmdCode,
   input wire logic [dram_host_pkg::ROW_W-1:0] cmdRow,
   input wire logic [dram_host_pkg::COL_W-1:0] cmdCol,
   input wire logic cmdHalfBit,
   input wire logic [dram_host_pkg::DATA_W-1:0] cmdData,
   output logic cmdReady,
   output logic rspValid,
   output logic [dram_host_pkg::DATA_W-1:0] rspData,
   output logic [dram_host_pkg::PD_W-1:0] presenceData,
   output logic selfActive,
   // module pins
   output logic rowStrobe_n,
   output logic colStrobe_n,
   output logic writeEnable_n,
   output logic outputEnable_n,
   output logic [dram_host_pkg::ADDR_W-1:0] addrPins,
   output logic low_half_addr_bit_zero,
   output logic high_half_addr_bit_zero,
   output logic [dram_host_pkg::DATA_W-1:0] dqOut,
   output logic dqOe,
   input wire logic [dram_host_pkg::DATA_W-1:0] dqIn,
   output logic presence_detect_gate_n,
   input wire logic [dram_host_pkg::PD_W-1:0] presence_detect_bits
);
   typedef enum {
      S_POWERUP, S_WAKE_LOW, S_WAKE_HIGH, S_IDLE, S_ROW, S_COL, S_COL_PRE,
      S_PRECHARGE, S_REF_COL, S_REF_ROW, S_SELF_HOLD, S_SELF_IDLE, S_SELF_EXIT, S_PD
   } phase_t;

   typedef struct packed {
      phase_t phase;
      logic [dram_host_pkg::TIMER_W-1:0] timer;
      logic [3:0] wakeCount;
      logic isWrite;
      logic isSelf;
      logic [dram_host_pkg::COL_W-1:0] col;
      logic halfBit;
      logic [dram_host_pkg::DATA_W-1:0] wdata;
      logic rspValid;
      logic [dram_host_pkg::DATA_W-1:0] rdata;
      logic [dram_host_pkg::PD_W-1:0] pd;
      logic selfActive;
   } state_t;
   state_t st;
   state_t next_st;

   logic refreshDue;
   logic refreshServed;
   logic [dram_host_pkg::ROW_W-1:0] cmdRowHeld;
   strobe_if link ();

   function automatic logic [dram_host_pkg::TIMER_W-1:0] cyc(input int n);
      cyc = dram_host_pkg::TIMER_W'(n - 1);
   endfunction

   refresh_timer #(
      .INTERVAL(REFRESH_INTERVAL)
   ) u_refresh (
      .mclk(mclk),
      .arst_n(arst_n),
      .served(refreshServed),
      .due(refreshDue)
   );

   dram_pin_driver u_pins (
      .mclk(mclk),
      .arst_n(arst_n),
      .req(link.pins),
      .wrData(st.wdata),
      .lowHalfBit(st.halfBit),
      .highHalfBit(st.halfBit),
      .rowStrobe_n(rowStrobe_n),
      .colStrobe_n(colStrobe_n),
      .writeEnable_n(writeEnable_n),
      .outputEnable_n(outputEnable_n),
      .addrPins(addrPins),
      .low_half_addr_bit_zero(low_half_addr_bit_zero),
      .high_half_addr_bit_zero(high_half_addr_bit_zero),
      .dqOut(dqOut),
      .dqOe(dqOe)
   );

   wire logic timerDone = (st.timer == '0);

   always_comb begin
      next_st = st;
      next_st.rspValid = 1'b0;
      refreshServed = 1'b0;
      if (!timerDone) begin
         next_st.timer = st.timer - 1'b1;
      end
      case (st.phase)
         S_POWERUP: begin
            if (timerDone) begin
               next_st.phase = S_WAKE_LOW;
               next_st.timer = cyc(dram_host_pkg::ROW_PULSE_CYC);
            end
         end
         S_WAKE_LOW: begin
            if (timerDone) begin
               next_st.phase = S_WAKE_HIGH;
               next_st.timer = cyc(dram_host_pkg::ROW_PRE_CYC);
               next_st.wakeCount = st.wakeCount + 1'b1;
            end
         end
         S_WAKE_HIGH: begin
            if (timerDone) begin
               // eight row-only cycles before normal use
               if (st.wakeCount == 4'(dram_host_pkg::WAKEUP_CYCLES)) begin
                  next_st.phase = S_IDLE;
               end else begin
                  next_st.phase = S_WAKE_LOW;
                  next_st.timer = cyc(dram_host_pkg::ROW_PULSE_CYC);
               end
            end
         end
         S_IDLE: begin
            // refresh takes priority so the period is never exceeded
            if (refreshDue) begin
               refreshServed = 1'b1;
               next_st.isSelf = 1'b0;
               next_st.phase = S_REF_COL;
               next_st.timer = cyc(dram_host_pkg::RCD_CYC);
            end else if (cmdValid) begin
               next_st.col = cmdCol;
               next_st.halfBit = cmdHalfBit;
               next_st.wdata = cmdData;
               next_st.isWrite = (cmdCode == dram_host_pkg::CMD_WRITE);
               case (cmdCode)
                  dram_host_pkg::CMD_READ, dram_host_pkg::CMD_WRITE: begin
                     next_st.phase = S_ROW;
                     next_st.timer = cyc(dram_host_pkg::RCD_CYC);
                  end
                  dram_host_pkg::CMD_SELF_ENTER: begin
                     refreshServed = 1'b1;
                     next_st.isSelf = 1'b1;
                     next_st.phase = S_REF_COL;
                     next_st.timer = cyc(dram_host_pkg::RCD_CYC);
                  end
                  dram_host_pkg::CMD_PRESENCE: begin
                     next_st.phase = S_PD;
                     next_st.timer = cyc(2);
                  end
                  default: begin
                  end
               endcase
            end
         end
         S_ROW: begin
            if (timerDone) begin
               next_st.phase = S_COL;
               next_st.timer = cyc(dram_host_pkg::COL_PULSE_CYC + 1);
            end
         end
         S_COL: begin
            if (timerDone) begin
               // sample read data while column is still low; valid for both page variants
               next_st.rdata = dqIn;
               next_st.rspValid = 1'b1;
               next_st.phase = S_COL_PRE;
               next_st.timer = cyc(dram_host_pkg::COL_PRE_CYC);
            end
         end
         S_COL_PRE: begin
            if (timerDone) begin
               next_st.phase = S_PRECHARGE;
               next_st.timer = cyc(dram_host_pkg::ROW_PRE_CYC + dram_host_pkg::TURNOFF_CYC);
            end
         end
         S_PRECHARGE: begin
            if (timerDone) begin
               next_st.phase = S_IDLE;
            end
         end
         S_REF_COL: begin
            if (timerDone) begin
               next_st.phase = S_REF_ROW;
               next_st.timer = st.isSelf ? cyc(SELF_PULSE_CYCLES)
                                         : cyc(dram_host_pkg::ROW_PULSE_CYC);
            end
         end
         S_REF_ROW: begin
            if (timerDone) begin
               if (st.isSelf) begin
                  next_st.phase = S_SELF_IDLE;
                  next_st.selfActive = 1'b1;
               end else begin
                  next_st.phase = S_PRECHARGE;
                  next_st.timer = cyc(dram_host_pkg::ROW_PRE_CYC);
               end
            end
         end
         S_SELF_IDLE: begin
            refreshServed = 1'b1;
            if (cmdValid && cmdCode == dram_host_pkg::CMD_SELF_EXIT) begin
               next_st.phase = S_SELF_EXIT;
               next_st.timer = cyc(dram_host_pkg::SELF_EXIT_CYC);
            end
         end
         S_SELF_EXIT: begin
            refreshServed = 1'b1;
            if (timerDone) begin
               // distributed refresh resumes, so no burst is issued
               next_st.phase = S_IDLE;
               next_st.selfActive = 1'b0;
            end
         end
         S_PD: begin
            if (timerDone) begin
               next_st.pd = presence_detect_bits;
               next_st.rspValid = 1'b1;
               next_st.phase = S_IDLE;
            end
         end
         default: begin
            next_st.phase = S_IDLE;
         end
      endcase
   end

   // strobe requests decoded from phase
   always_comb begin
      link.rowStrobe = st.phase inside {S_WAKE_LOW, S_ROW, S_COL, S_COL_PRE, S_REF_ROW,
                                        S_SELF_IDLE};
      link.colStrobe = st.phase inside {S_COL, S_REF_COL, S_REF_ROW, S_SELF_IDLE};
      link.writeSel = st.isWrite && st.phase inside {S_ROW, S_COL};
      // outputs only enabled for reads; idle banks kept off
      link.outGate = !st.isWrite && st.phase == S_COL;
      link.addr = (st.phase == S_ROW) ? cmdRowHeld : st.col;
      link.driveData = st.isWrite && st.phase inside {S_ROW, S_COL};
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmdRowHeld <= '0;
      end else if (st.phase == S_IDLE && cmdValid) begin
         cmdRowHeld <= cmdRow;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{phase: S_POWERUP, timer: dram_host_pkg::TIMER_W'(POWERUP_CYCLES - 1),
                 wakeCount: '0, isWrite: 1'b0, isSelf: 1'b0, col: '0, halfBit: 1'b0,
                 wdata: '0, rspValid: 1'b0, rdata: '0, pd: '0, selfActive: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign cmdReady = (st.phase == S_IDLE && !refreshDue) ||
                     (st.phase == S_SELF_IDLE && cmdCode == dram_host_pkg::CMD_SELF_EXIT);
   assign rspValid = st.rspValid;
   assign rspData = st.rdata;
   assign presenceData = st.pd;
   assign selfActive = st.selfActive;
   assign presence_detect_gate_n = (st.phase != S_PD);

   // wake-up sequence gives exactly eight row pulses before idle
   wakeup_count_a: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(st.phase == S_IDLE) && $past(st.phase) == S_WAKE_HIGH
      |-> st.wakeCount == 4'd8) else $error("wake-up count wrong");
   sequence colFirst;
      !colStrobe_n && rowStrobe_n;
   endsequence
   ref_order_a: assert property (@(posedge mclk) disable iff (!arst_n)
      colFirst ##1 !rowStrobe_n |-> !colStrobe_n) else $error("row fell before column");
   early_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
      $fell(colStrobe_n) && !writeEnable_n |-> outputEnable_n) else $error("oe on in write");
   // pins lag the phase by one register stage
   exit_precharge_a: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(st.phase == S_SELF_EXIT) |-> ##1 rowStrobe_n [*6]) else $error("exit too short");
   sequence colFallInRow;
      $fell(colStrobe_n) && !rowStrobe_n;
   endsequence
   // host drives data exactly when it selects a write
   write_select_a: assert property (@(posedge mclk) disable iff (!arst_n)
      colFallInRow |-> writeEnable_n != dqOe) else $error("write select wrong");
   idle_oe_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
      rowStrobe_n |-> outputEnable_n) else $error("idle bank output on");
endmodule // dram_module_host

// ==== inc/dram_host_pkg.sv ====
// constants and types for the dram module host controller
package dram_host_pkg;
   localparam int CLK_PERIOD_NS = 25;
   // link widths
   localparam int ADDR_W = 11;
   localparam int ROW_W = 11;
   localparam int COL_W = 11;
   localparam int DATA_W = 64;
   localparam int PD_W = 8;
   // documented times in their own units
   localparam int POWERUP_PAUSE_US = 100;
   localparam int WAKEUP_CYCLES = 8;
   localparam int SELF_ROW_PULSE_MIN_US = 100;
   localparam int SELF_EXIT_PRECHARGE_NS = 130;
   localparam int OUTPUT_TURNOFF_NS = 25;
   localparam int REFRESH_PERIOD_MS = 32;
   localparam int REFRESH_ROWS = 2048;
   localparam int DIST_REFRESH_NS = 62500;
   localparam int BURST_WINDOW_US = 300;
   localparam int ROW_PULSE_NS = 70;
   localparam int ROW_PRECHARGE_NS = 50;
   localparam int ROW_TO_COL_NS = 18;
   localparam int COL_PULSE_NS = 25;
   localparam int COL_PRECHARGE_NS = 10;
   // derived cycle counts: minimums round up, maximums round down
   localparam int POWERUP_CYC = (POWERUP_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELF_PULSE_CYC =
      (SELF_ROW_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELF_EXIT_CYC = (SELF_EXIT_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TURNOFF_CYC = (OUTPUT_TURNOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIST_REFRESH_CYC = DIST_REFRESH_NS / CLK_PERIOD_NS;
   localparam int BURST_WINDOW_CYC = BURST_WINDOW_US * 1000 / CLK_PERIOD_NS;
   localparam int ROW_PULSE_CYC = (ROW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ROW_PRE_CYC = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RCD_CYC = (ROW_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COL_PULSE_CYC = (COL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COL_PRE_CYC = (COL_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 24;
   // host command codes
   typedef enum logic [2:0] {
      CMD_READ,
      CMD_WRITE,
      CMD_SELF_ENTER,
      CMD_SELF_EXIT,
      CMD_PRESENCE
   } cmd_t;
endpackage

// ==== inc/strobe_if.sv ====
// strobe request bundle between sequencer and pin driver
`timescale 1ns/100ps
interface strobe_if;
   logic rowStrobe;
   logic colStrobe;
   logic writeSel;
   logic outGate;
   logic [dram_host_pkg::ADDR_W-1:0] addr;
   logic driveData;
   modport seq (output rowStrobe, colStrobe, writeSel, outGate, addr, driveData);
   modport pins (input rowStrobe, colStrobe, writeSel, outGate, addr, driveData);
endinterface

// ==== core/refresh_timer.sv ====
// distributed refresh interval timer with sticky due flag
`timescale 1ns/100ps
module refresh_timer #(
   parameter int INTERVAL = dram_host_pkg::DIST_REFRESH_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // control
   input wire logic served,
   output logic due
);
   typedef struct packed {
      logic [dram_host_pkg::TIMER_W-1:0] count;
      logic due;
   } state_t;
   state_t st;
   state_t next_st;

   always_comb begin
      next_st = st;
      if (st.count == dram_host_pkg::TIMER_W'(INTERVAL - 1)) begin
         next_st.count = '0;
      end else begin
         next_st.count = st.count + 1'b1;
      end
      if (served) begin
         next_st.due = 1'b0;
      end
      // a tick in the serving cycle is kept
      if (st.count == dram_host_pkg::TIMER_W'(INTERVAL - 1)) begin
         next_st.due = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign due = st.due;
endmodule // refresh_timer

// ==== core/dram_pin_driver.sv ====
// registers strobe and data pins toward the module
`timescale 1ns/100ps
module dram_pin_driver (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // from sequencer
   strobe_if.pins req,
   input wire logic [dram_host_pkg::DATA_W-1:0] wrData,
   input wire logic lowHalfBit,
   input wire logic highHalfBit,
   // module pins
   output logic rowStrobe_n,
   output logic colStrobe_n,
   output logic writeEnable_n,
   output logic outputEnable_n,
   output logic [dram_host_pkg::ADDR_W-1:0] addrPins,
   output logic low_half_addr_bit_zero,
   output logic high_half_addr_bit_zero,
   output logic [dram_host_pkg::DATA_W-1:0] dqOut,
   output logic dqOe
);
   typedef struct packed {
      logic ras;
      logic cas;
      logic we;
      logic oe;
      logic [dram_host_pkg::ADDR_W-1:0] addr;
      logic lowBit;
      logic highBit;
      logic [dram_host_pkg::DATA_W-1:0] dq;
      logic dqOe;
   } state_t;
   state_t st;
   state_t next_st;

   always_comb begin
      next_st.ras = ~req.rowStrobe;
      next_st.cas = ~req.colStrobe;
      next_st.we = ~req.writeSel;
      next_st.oe = ~req.outGate;
      next_st.addr = req.addr;
      next_st.lowBit = lowHalfBit;
      next_st.highBit = highHalfBit;
      next_st.dq = wrData;
      next_st.dqOe = req.driveData;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{ras: 1'b1, cas: 1'b1, we: 1'b1, oe: 1'b1, addr: '0, lowBit: 1'b0, highBit: 1'b0,
                 dq: '0, dqOe: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign rowStrobe_n = st.ras;
   assign colStrobe_n = st.cas;
   assign writeEnable_n = st.we;
   assign outputEnable_n = st.oe;
   assign addrPins = st.addr;
   assign low_half_addr_bit_zero = st.lowBit;
   assign high_half_addr_bit_zero = st.highBit;
   assign dqOut = st.dq;
   assign dqOe = st.dqOe;
endmodule // dram_pin_driver

// ==== testbench/dram_module_model.sv ====
// behavioural dram module answering the host pins
`timescale 1ns/100ps
module dram_module_model #(
   parameter int SELF_PULSE_CYCLES = 20,
   parameter bit FAST_PAGE = 1'b0,
   parameter logic [7:0] PD_VALUE = 8'h5a
) (
   // strobes and address
   input wire logic rowStrobe_n,
   input wire logic colStrobe_n,
   input wire logic writeEnable_n,
   input wire logic outputEnable_n,
   input wire logic [10:0] addrPins,
   input wire logic low_half_addr_bit_zero,
   input wire logic high_half_addr_bit_zero,
   // data and presence
   input wire logic [63:0] dqOut,
   input wire logic dqOe,
   output logic [63:0] dqIn,
   input wire logic presence_detect_gate_n,
   output logic [7:0] presence_detect_bits
);
   logic [63:0] mem [logic [23:0]];
   logic [23:0] key;
   logic [10:0] row;
   logic [10:0] col;
   logic [1:0] bits;
   logic [63:0] q = '0;
   logic valid = 1'b0;
   logic colFirst = 1'b0;
   logic selfExit = 1'b0;
   int rowOnly = 0;
   int colFirstCount = 0;
   int selfCount = 0;
   int viol = 0;
   realtime fallAt = 0;
   realtime riseAt = -1000;
   realtime firstFall = -1;
   // released lines show the inverse, so a late sample cannot pass by luck
   assign dqIn = (valid && !outputEnable_n) ? q : ~q;
   assign presence_detect_bits = presence_detect_gate_n ? 8'hff : PD_VALUE;
   task automatic store();
      if (dqOe !== 1'b1) viol++;
      mem[key] = dqOut;
   endtask
   always @(negedge rowStrobe_n) begin
      fallAt = $realtime;
      if (firstFall < 0) firstFall = fallAt;
      if (fallAt - riseAt < (selfExit ? dram_host_pkg::SELF_EXIT_PRECHARGE_NS :
            dram_host_pkg::ROW_PRECHARGE_NS)) viol++;
      selfExit = 1'b0;
      colFirst = !colStrobe_n;
      if (colFirst) colFirstCount++;
      else begin
         row = addrPins;
         rowOnly++;
      end
   end
   always @(posedge rowStrobe_n) begin
      riseAt = $realtime;
      if (colStrobe_n) valid = 1'b0;
      if (colFirst && riseAt - fallAt >= SELF_PULSE_CYCLES * dram_host_pkg::CLK_PERIOD_NS) begin
         selfCount++;
         selfExit = 1'b1;
      end
   end
   always @(negedge colStrobe_n) if (!rowStrobe_n) begin
      col = addrPins;
      bits = {low_half_addr_bit_zero, high_half_addr_bit_zero};
      key = {row, col, bits};
      valid = writeEnable_n;
      if (!writeEnable_n) store();
      else q = mem.exists(key) ? mem[key] : '1;
   end
   // a later write fall overwrites what the column fall took
   always @(negedge writeEnable_n) begin
      if (colStrobe_n) valid = 1'b0;
      else if (!rowStrobe_n) store();
   end
   // fast page drops data on every column rise
   always @(posedge colStrobe_n)
      if (FAST_PAGE || rowStrobe_n || outputEnable_n) valid = 1'b0;
   always @(posedge outputEnable_n) if (colStrobe_n) valid = 1'b0;
   always @(posedge dqOe) if (valid && !outputEnable_n) viol++;
endmodule // dram_module_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the dram module host controller
`timescale 1ns/100ps
module tb_top;
   localparam int PWR = 50;
   localparam int SELF = 20;
   localparam int RIVL = 200;
   logic mclk;
   logic arst_n;
   logic cmdValid;
   dram_host_pkg::cmd_t cmdCode;
   logic [10:0] cmdRow;
   logic [10:0] cmdCol;
   logic cmdHalfBit;
   logic [63:0] cmdData;
   logic cmdReady;
   logic rspValid;
   logic [63:0] rspData;
   logic [7:0] presenceData;
   logic selfActive;
   logic rowStrobe_n;
   logic colStrobe_n;
   logic writeEnable_n;
   logic outputEnable_n;
   logic [10:0] addrPins;
   logic low_half_addr_bit_zero;
   logic high_half_addr_bit_zero;
   logic [63:0] dqOut;
   logic dqOe;
   logic [63:0] dqIn;
   logic presence_detect_gate_n;
   logic [7:0] presence_detect_bits;
   int n_mismatch = 0;
   int checks = 0;
   realtime relAt;
   logic [10:0] ra [16];
   logic [10:0] ka [16];
   logic ha [16];
   logic [63:0] da [16];

   dram_module_host #(.POWERUP_CYCLES(PWR), .SELF_PULSE_CYCLES(SELF), .REFRESH_INTERVAL(RIVL))
   dram_module_host_inst (.mclk, .arst_n, .cmdValid, .cmdCode, .cmdRow, .cmdCol, .cmdHalfBit,
      .cmdData, .cmdReady, .rspValid, .rspData, .presenceData, .selfActive, .rowStrobe_n,
      .colStrobe_n, .writeEnable_n, .outputEnable_n, .addrPins, .low_half_addr_bit_zero,
      .high_half_addr_bit_zero, .dqOut, .dqOe, .dqIn, .presence_detect_gate_n,
      .presence_detect_bits);

   dram_module_model #(.SELF_PULSE_CYCLES(SELF), .PD_VALUE(8'h5a))
   dram_module_model_inst (.rowStrobe_n, .colStrobe_n, .writeEnable_n, .outputEnable_n,
      .addrPins, .low_half_addr_bit_zero, .high_half_addr_bit_zero, .dqOut, .dqOe, .dqIn,
      .presence_detect_gate_n, .presence_detect_bits);

   task automatic end_sim();
      $display("counts checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(inout int n, input int lim);
      n++;
      if (n > lim) begin
         n_mismatch++;
         $display("test timeout at %0t", $time);
         end_sim();
      end
   endtask

   // request held from a falling edge until ready is seen, dropped one cycle on
   task automatic issue(input dram_host_pkg::cmd_t c, input int i);
      int n;
      n = 0;
      @(negedge mclk);
      cmdValid = 1'b1;
      cmdCode = c;
      cmdRow = ra[i];
      cmdCol = ka[i];
      cmdHalfBit = ha[i];
      cmdData = da[i];
      #1;
      while (cmdReady !== 1'b1) begin
         @(negedge mclk);
         #1;
         tick(n, 3000);
      end
      @(negedge mclk);
      cmdValid = 1'b0;
   endtask

   // refreshes expected in a span of idle cycles, one per interval
   function automatic int expRefresh(input int span);
      return span / RIVL;
   endfunction

   task automatic waitRsp();
      int n;
      n = 0;
      while (rspValid !== 1'b1) begin
         @(negedge mclk);
         tick(n, 50);
      end
   endtask

   task automatic waitSelf(input logic lvl);
      int n;
      n = 0;
      while (selfActive !== lvl) begin
         @(negedge mclk);
         tick(n, 3000);
      end
   endtask

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   initial begin
      int n;
      int c0;
      int r0;
      n = $urandom(4);
      arst_n = 1'b0;
      cmdValid = 1'b0;
      cmdCode = dram_host_pkg::CMD_READ;
      cmdRow = '0;
      cmdCol = '0;
      cmdHalfBit = 1'b0;
      cmdData = '0;
      // entries 0 and 1 are the all-zero and all-one corners
      for (int i = 0; i < 16; i++) begin
         ra[i] = (i < 2) ? {11{i[0]}} : 11'($urandom);
         ka[i] = (i < 2) ? {11{i[0]}} : {7'($urandom), 4'(i)};
         ha[i] = (i < 2) ? i[0] : 1'($urandom);
         da[i] = (i < 2) ? {64{i[0]}} : {$urandom, $urandom};
      end
      repeat (16) @(negedge mclk);
      arst_n = 1'b1;
      relAt = $realtime;
      n = 0;
      #1;
      while (cmdReady !== 1'b1) begin
         @(negedge mclk);
         #1;
         tick(n, 3000);
      end
      chk(dram_module_model_inst.rowOnly, 8);
      chk(dram_module_model_inst.firstFall - relAt >= PWR * 25.0, 1);
      $display("test wakeup done");
      for (int i = 0; i < 16; i++) issue(dram_host_pkg::CMD_WRITE, i);
      for (int i = 15; i >= 0; i--) begin
         issue(dram_host_pkg::CMD_READ, i);
         waitRsp();
         chk(rspData, da[i]);
         chk(dram_module_model_inst.row, ra[i]);
         chk(dram_module_model_inst.col, ka[i]);
         chk(dram_module_model_inst.bits, {ha[i], ha[i]});
      end
      $display("test access done");
      issue(dram_host_pkg::CMD_PRESENCE, 0);
      waitRsp();
      chk(presenceData, 8'h5a);
      $display("test presence done");
      c0 = dram_module_model_inst.colFirstCount;
      repeat (5 * RIVL) @(negedge mclk);
      c0 = dram_module_model_inst.colFirstCount - c0;
      r0 = expRefresh(5 * RIVL);
      chk(c0 >= r0 - 1 && c0 <= r0 + 1, 1);
      $display("test refresh done");
      c0 = dram_module_model_inst.selfCount;
      issue(dram_host_pkg::CMD_SELF_ENTER, 0);
      waitSelf(1'b1);
      // a read offered in self refresh must be held off with the row kept low
      @(negedge mclk);
      cmdValid = 1'b1;
      cmdCode = dram_host_pkg::CMD_READ;
      n = 0;
      repeat (2 * SELF) begin
         @(negedge mclk);
         #1;
         if (cmdReady !== 1'b0 || rowStrobe_n !== 1'b0) n++;
      end
      chk(n, 0);
      r0 = dram_module_model_inst.rowOnly;
      issue(dram_host_pkg::CMD_SELF_EXIT, 0);
      waitSelf(1'b0);
      issue(dram_host_pkg::CMD_READ, 5);
      waitRsp();
      chk(rspData, da[5]);
      chk(dram_module_model_inst.rowOnly, r0 + 1);
      chk(dram_module_model_inst.selfCount, c0 + 1);
      chk(dram_module_model_inst.viol, 0);
      $display("test self refresh done");
      end_sim();
   end
endmodule // tb_top
